// [rtl/nvsd_host.sv]
// host controller driving the nonvolatile static memory pins
`timescale 1ns/1ns
`include "nvsd_consts.svh"

// Overview of operation
// - save: six reads 0e38,31c7,03e0,3c1f,303f then 0fc0
// - restore: same five-read prefix, sixth read at 0c63
// - power-fail save off: prefix then sixth read at 0b45
// - power-fail save on: prefix then sixth read at 0b46
// - any other access between sequence reads aborts it; reads go back to back
// - write strobe stays high during all six sequence reads
// - sequence reads may be chip-enable or output-enable timed
// - a save must follow any power-fail save setting change
module nvsd_host #(
    parameter int unsigned RESTORE_CYC = `NVSD_RESTORE_CYC
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire nvsd_pkg::nvsd_op_t cmd_op,
    input  wire logic [14:0]       cmd_addr,
    input  wire logic [7:0]        cmd_wdata,
    output logic                   rsp_valid,
    output logic [7:0]             rsp_rdata,
    output logic                   mem_ce_n,
    output logic                   mem_oe_n,
    output logic                   mem_we_n,
    output logic [14:0]            mem_addr,
    output logic [7:0]             dq_out,
    output logic                   dq_oe,
    input  wire logic [7:0]        dq_in,
    input  wire logic              busy_store_n
);

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    typedef struct packed {
        nvsd_pkg::nvsd_state_t st;
        nvsd_pkg::nvsd_op_t    op;
        logic [2:0]            step;
        logic [31:0]           cnt;
        logic [14:0]           addr;
        logic [7:0]            wdata;
        logic [7:0]            rdata;
        logic                  ce_n;
        logic                  oe_n;
        logic                  we_n;
        logic                  dq_oe;
        logic                  rsp_valid;
    } nvsd_host_t;

    localparam nvsd_host_t RST = '{
        st: nvsd_pkg::S_IDLE, op: nvsd_pkg::OP_READ, step: 3'h0, cnt: 32'h0,
        addr: 15'h0, wdata: 8'h0, rdata: 8'h0, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, dq_oe: 1'b0, rsp_valid: 1'b0};

    nvsd_host_t s;
    nvsd_host_t next_s;
    logic [8:0] pins_s;
    logic       busy_ok;
    logic       is_write;
    logic       is_seq;

    // ----------------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------------
    nvsd_sync u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .d    ({busy_store_n, dq_in}),
        .q    (pins_s)
    );

    assign busy_ok  = pins_s[8];
    assign is_write = (s.op == nvsd_pkg::OP_WRITE);
    assign is_seq   = (s.op != nvsd_pkg::OP_READ) && !is_write;

    function automatic logic [14:0] seq_addr(input logic [2:0] step,
                                             input nvsd_pkg::nvsd_op_t op);
        logic [14:0] a;
        a = `NVSD_SEQ_A0;
        case (step)
            3'h0: a = `NVSD_SEQ_A0;
            3'h1: a = `NVSD_SEQ_A1;
            3'h2: a = `NVSD_SEQ_A2;
            3'h3: a = `NVSD_SEQ_A3;
            3'h4: a = `NVSD_SEQ_A4;
            default: begin
                case (op)
                    nvsd_pkg::OP_RESTORE:   a = `NVSD_SEQ_RESTORE;
                    nvsd_pkg::OP_PSAVE_OFF: a = `NVSD_SEQ_PSAVE_OFF;
                    nvsd_pkg::OP_PSAVE_ON:  a = `NVSD_SEQ_PSAVE_ON;
                    default:                a = `NVSD_SEQ_SAVE;
                endcase
            end
        endcase
        return a;
    endfunction

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.rsp_valid = 1'b0;
        case (s.st)
            nvsd_pkg::S_IDLE: begin
                // no access is started while the device holds busy low
                if (cmd_valid && busy_ok) begin
                    next_s.op    = cmd_op;
                    next_s.wdata = cmd_wdata;
                    next_s.step  = 3'h0;
                    next_s.st    = nvsd_pkg::S_SETUP;
                    if (cmd_op == nvsd_pkg::OP_READ || cmd_op == nvsd_pkg::OP_WRITE) begin
                        next_s.addr = cmd_addr;
                    end else begin
                        next_s.addr = seq_addr(3'h0, cmd_op);
                    end
                end
            end
            nvsd_pkg::S_SETUP: begin
                // chip-enable timed access; sequence reads keep write high
                next_s.ce_n  = 1'b0;
                next_s.oe_n  = is_write;
                next_s.we_n  = !is_write;
                next_s.dq_oe = is_write;
                next_s.cnt   = 32'(`NVSD_STROBE_CYC - 1);
                next_s.st    = nvsd_pkg::S_STROBE;
            end
            nvsd_pkg::S_STROBE: begin
                if (s.cnt == 32'h0) begin
                    next_s.ce_n  = 1'b1;
                    next_s.oe_n  = 1'b1;
                    next_s.we_n  = 1'b1;
                    next_s.rdata = pins_s[7:0];
                    next_s.st    = nvsd_pkg::S_GAP;
                end else begin
                    next_s.cnt = s.cnt - 32'h1;
                end
            end
            nvsd_pkg::S_GAP: begin
                next_s.dq_oe = 1'b0;
                if (!is_seq) begin
                    next_s.rsp_valid = 1'b1;
                    next_s.st        = nvsd_pkg::S_IDLE;
                end else if (s.step != `NVSD_SEQ_LAST_STEP) begin
                    // next sequence read follows at once, nothing in between
                    next_s.step = s.step + 3'h1;
                    next_s.addr = seq_addr(s.step + 3'h1, s.op);
                    next_s.st   = nvsd_pkg::S_SETUP;
                end else begin
                    case (s.op)
                        nvsd_pkg::OP_SAVE: begin
                            next_s.cnt = 32'(`NVSD_BUSY_WAIT_CYC - 1);
                            next_s.st  = nvsd_pkg::S_BUSY_LO;
                        end
                        nvsd_pkg::OP_RESTORE: begin
                            next_s.cnt = RESTORE_CYC + 32'(`NVSD_POST_CYC) - 32'h1;
                            next_s.st  = nvsd_pkg::S_TIME;
                        end
                        default: begin
                            // setting change is made lasting by a save
                            next_s.op   = nvsd_pkg::OP_SAVE;
                            next_s.step = 3'h0;
                            next_s.addr = seq_addr(3'h0, nvsd_pkg::OP_SAVE);
                            next_s.st   = nvsd_pkg::S_SETUP;
                        end
                    endcase
                end
            end
            nvsd_pkg::S_BUSY_LO: begin
                if (!busy_ok || s.cnt == 32'h0) begin
                    next_s.st = nvsd_pkg::S_BUSY_HI;
                end else begin
                    next_s.cnt = s.cnt - 32'h1;
                end
            end
            nvsd_pkg::S_BUSY_HI: begin
                if (busy_ok) begin
                    next_s.cnt = 32'(`NVSD_POST_CYC - 1);
                    next_s.st  = nvsd_pkg::S_TIME;
                end
            end
            nvsd_pkg::S_TIME: begin
                if (s.cnt == 32'h0) begin
                    next_s.rsp_valid = 1'b1;
                    next_s.st        = nvsd_pkg::S_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 32'h1;
                end
            end
            default: next_s = RST;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign cmd_ready = (s.st == nvsd_pkg::S_IDLE) && busy_ok;
    assign rsp_valid = s.rsp_valid;
    assign rsp_rdata = s.rdata;
    assign mem_ce_n  = s.ce_n;
    assign mem_oe_n  = s.oe_n;
    assign mem_we_n  = s.we_n;
    assign mem_addr  = s.addr;
    assign dq_out    = s.wdata;
    assign dq_oe     = s.dq_oe;

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    a_seq_no_write: assert property (@(posedge mclk) disable iff (!nrst)
        is_seq |-> (mem_we_n && !dq_oe)) else $error("write during sequence");

    a_seq_read_strobe: assert property (@(posedge mclk) disable iff (!nrst)
        (is_seq && !mem_ce_n) |-> !mem_oe_n) else $error("sequence read not strobed");

    a_seq_first_addr: assert property (@(posedge mclk) disable iff (!nrst)
        (is_seq && s.step == 3'h0 && !mem_ce_n) |-> mem_addr == `NVSD_SEQ_A0)
        else $error("bad first sequence address");

    a_save_last_addr: assert property (@(posedge mclk) disable iff (!nrst)
        (s.op == nvsd_pkg::OP_SAVE && s.step == 3'h5 && !mem_ce_n)
        |-> mem_addr == `NVSD_SEQ_SAVE) else $error("bad save address");

    a_restore_last_addr: assert property (@(posedge mclk) disable iff (!nrst)
        (s.op == nvsd_pkg::OP_RESTORE && s.step == 3'h5 && !mem_ce_n)
        |-> mem_addr == `NVSD_SEQ_RESTORE) else $error("bad restore address");

    a_psave_off_addr: assert property (@(posedge mclk) disable iff (!nrst)
        (s.op == nvsd_pkg::OP_PSAVE_OFF && s.step == 3'h5 && !mem_ce_n)
        |-> mem_addr == `NVSD_SEQ_PSAVE_OFF) else $error("bad disable address");

    a_psave_on_addr: assert property (@(posedge mclk) disable iff (!nrst)
        (s.op == nvsd_pkg::OP_PSAVE_ON && s.step == 3'h5 && !mem_ce_n)
        |-> mem_addr == `NVSD_SEQ_PSAVE_ON) else $error("bad enable address");

    a_seq_back_to_back: assert property (@(posedge mclk) disable iff (!nrst)
        (is_seq && s.st == nvsd_pkg::S_GAP && s.step != 3'h5)
        |=> (s.st == nvsd_pkg::S_SETUP) ##1 !mem_ce_n) else $error("sequence gap");

    a_setting_then_save: assert property (@(posedge mclk) disable iff (!nrst)
        (s.st == nvsd_pkg::S_GAP && s.step == 3'h5 &&
         (s.op == nvsd_pkg::OP_PSAVE_OFF || s.op == nvsd_pkg::OP_PSAVE_ON))
        |=> (s.op == nvsd_pkg::OP_SAVE && s.step == 3'h0 && !rsp_valid))
        else $error("no save after setting change");

    a_busy_blocks_start: assert property (@(posedge mclk) disable iff (!nrst)
        (!busy_ok && s.st == nvsd_pkg::S_IDLE) |-> !cmd_ready ##1 mem_ce_n)
        else $error("access started while busy");

    a_post_busy_wait: assert property (@(posedge mclk) disable iff (!nrst)
        (s.st == nvsd_pkg::S_BUSY_HI && busy_ok)
        |=> (!cmd_ready && mem_ce_n)[*2]) else $error("access before post delay");

endmodule // nvsd_host

// [rtl/nvsd_consts.svh]
// constants of the nonvolatile memory sequence host: addresses and timing
`ifndef NVSD_CONSTS_SVH
`define NVSD_CONSTS_SVH

// --------------------------------------------------------------------------
// sequence addresses
// --------------------------------------------------------------------------
`define NVSD_SEQ_A0         15'h0e38
`define NVSD_SEQ_A1         15'h31c7
`define NVSD_SEQ_A2         15'h03e0
`define NVSD_SEQ_A3         15'h3c1f
`define NVSD_SEQ_A4         15'h303f
`define NVSD_SEQ_SAVE       15'h0fc0
`define NVSD_SEQ_RESTORE    15'h0c63
`define NVSD_SEQ_PSAVE_OFF  15'h0b45
`define NVSD_SEQ_PSAVE_ON   15'h0b46
`define NVSD_SEQ_LAST_STEP  3'h5

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define NVSD_CLK_NS         10
`define NVSD_SYNC_CYC       3
`define NVSD_T_ACC_NS       35
`define NVSD_ACC_CYC        ((`NVSD_T_ACC_NS + `NVSD_CLK_NS - 1) / `NVSD_CLK_NS)
`define NVSD_STROBE_CYC     (`NVSD_ACC_CYC + `NVSD_SYNC_CYC)
`define NVSD_T_POST_NS      20
`define NVSD_POST_CYC       ((`NVSD_T_POST_NS + `NVSD_CLK_NS - 1) / `NVSD_CLK_NS)
`define NVSD_T_BUSY_WAIT_NS 500
`define NVSD_BUSY_WAIT_CYC  ((`NVSD_T_BUSY_WAIT_NS + `NVSD_CLK_NS - 1) / `NVSD_CLK_NS)
`define NVSD_T_RESTORE_US   200
`define NVSD_RESTORE_CYC    ((`NVSD_T_RESTORE_US * 1000 + `NVSD_CLK_NS - 1) / `NVSD_CLK_NS)

`endif

// [rtl/nvsd_pkg.sv]
// types of the nonvolatile memory sequence host
package nvsd_pkg;

    // ----------------------------------------------------------------------
    // user commands
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_SAVE,
        OP_RESTORE,
        OP_PSAVE_OFF,
        OP_PSAVE_ON
    } nvsd_op_t;

    // ----------------------------------------------------------------------
    // controller states
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_GAP,
        S_BUSY_LO,
        S_BUSY_HI,
        S_TIME
    } nvsd_state_t;

endpackage

// [rtl/nvsd_sync.sv]
// three-stage pin synchroniser, output changes once stages two and three agree
`timescale 1ns/1ns
module nvsd_sync (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [8:0] d,
    output logic      [8:0] q
);

    typedef struct packed {
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic [8:0] q;
    } nvsd_sync_t;

    nvsd_sync_t s;
    nvsd_sync_t next_s;

    always_comb begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q  = (~(s.s2 ^ s.s3) & s.s2) | ((s.s2 ^ s.s3) & s.q);
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s <= '{s1: 9'h1ff, s2: 9'h1ff, s3: 9'h1ff, q: 9'h1ff};
        end else begin
            s <= next_s;
        end
    end

    assign q = s.q;

endmodule // nvsd_sync

// [bench/nvsd_mem_model.sv]
// behavioural model of the nonvolatile static memory on the host's pins
`timescale 1ns/1ns
module nvsd_mem_model #(
    parameter int SAVE_NS = 400,
    parameter int REST_NS = 150,
    parameter int POST_NS = 15
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  din,
    output logic      [7:0]  dout,
    output logic             busy_store_n
);
    localparam logic [14:0] PFX [5] = '{15'h0e38, 15'h31c7, 15'h03e0, 15'h3c1f, 15'h303f};
    localparam logic [14:0] SV = 15'h0fc0;
    localparam logic [14:0] RS = 15'h0c63;
    localparam logic [14:0] PF = 15'h0b45;
    logic [7:0] sram [32768];
    logic [7:0] nv   [32768];
    logic [7:0] last;
    logic       busy;
    logic       power_fail_save;
    logic       core_ok;
    logic       io_ok;
    int         step;
    int         bad_cnt;
    event       go_save;
    event       go_rest;
    wire logic  rd_on = !ce_n && !oe_n && we_n;
    wire logic  wr_on = !ce_n && !we_n;

    initial begin
        sram = '{default: 8'h00};
        nv = '{default: 8'h00};
        power_fail_save = 1'b1;
        busy = 1'b0;
        core_ok = 1'b1;
        io_ok = 1'b1;
        busy_store_n = 1'b1;
        last = 8'h00;
        step = 0;
        bad_cnt = 0;
    end

    // released bus shows the inverse of the last byte driven
    always @(rd_on or addr or busy or io_ok) begin
        if (rd_on && !busy && io_ok) begin
            dout = sram[addr];
            last = dout;
        end else begin
            dout = ~last;
        end
    end

    // ----------------------------------------------------------------
    // sequence detection, any strobe ordering
    // ----------------------------------------------------------------
    always @(posedge rd_on) begin
        if (busy) begin
            bad_cnt++;
        end else if (step == 5) begin
            step = int'(addr[14:2] == PFX[0][14:2]);
            if (addr[14:2] == SV[14:2] && core_ok && io_ok) begin
                busy = 1'b1;
                -> go_save;
            end else if (addr[14:2] == RS[14:2]) begin
                busy = 1'b1;
                -> go_rest;
            end else if (addr[14:2] == PF[14:2]) begin
                // off and on share bits 14:2, bit 1 picks the setting
                power_fail_save = addr[1];
            end
        end else begin
            step = (addr[14:2] == PFX[step][14:2]) ? step + 1
                 : int'(addr[14:2] == PFX[0][14:2]);
        end
    end

    always @(negedge wr_on) begin
        step = 0;
        if (busy) begin
            bad_cnt++;
        end else if (core_ok) begin
            sram[addr] = din;
        end
    end

    always @(go_save) begin
        busy = 1'b1;
        #20 busy_store_n = 1'b0;
        nv = sram;
        #SAVE_NS busy_store_n = 1'b1;
        #POST_NS busy = 1'b0;
    end

    always @(go_rest) begin
        sram = '{default: 8'h00};
        sram = nv;
        #REST_NS busy = 1'b0;
    end
endmodule // nvsd_mem_model

// [bench/testbench.sv]
// self-checking bench for the nonvolatile memory sequence host
`timescale 1ns/1ns
module testbench;
    localparam logic [14:0] PFX [5] = '{15'h0e38, 15'h31c7, 15'h03e0, 15'h3c1f, 15'h303f};
    logic               mclk = 1'b0;
    logic               nrst, cmd_valid, cmd_ready, rsp_valid, exp_psave;
    logic               mem_ce_n, mem_oe_n, mem_we_n, dq_oe, busy_store_n, ce_q;
    nvsd_pkg::nvsd_op_t cmd_op;
    logic [14:0]        cmd_addr, mem_addr;
    logic [7:0]         cmd_wdata, rsp_rdata, dq_out, dq_dev, dq_bus;
    logic [7:0]         exp_mem [32768];
    logic [7:0]         exp_nv  [32768];
    logic [16:0]        pin_log [$];
    logic [16:0]        want_q  [$];
    int                 error_cnt, n_checks, seed, busy_lows, i;

    assign dq_bus = dq_oe ? dq_out : dq_dev;
    always #5 mclk = ~mclk;

    nvsd_host #(.RESTORE_CYC(20)) u_nvsd_host (
        .mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_ce_n(mem_ce_n),
        .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus), .busy_store_n(busy_store_n));

    nvsd_mem_model u_nvsd_mem_model (
        .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .addr(mem_addr),
        .din(dq_bus), .dout(dq_dev), .busy_store_n(busy_store_n));

    // ----------------------------------------------------------------
    // pin monitor: strobes and address at each access start
    // ----------------------------------------------------------------
    always @(negedge busy_store_n) busy_lows++;
    always @(posedge mclk) begin
        ce_q <= mem_ce_n;
        if (nrst === 1'b1 && ce_q === 1'b1 && mem_ce_n === 1'b0)
            pin_log.push_back({mem_oe_n, mem_we_n, mem_addr});
    end

    task automatic results;
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("Error %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    function automatic void add_seq(input logic [14:0] last);
        for (int k = 0; k < 5; k++) want_q.push_back({2'b01, PFX[k]});
        want_q.push_back({2'b01, last});
    endfunction

    task automatic run(input nvsd_pkg::nvsd_op_t op, input logic [14:0] ad,
                       input logic [7:0] wd);
        int n;
        int b;
        n = 0;
        b = busy_lows;
        pin_log.delete();
        want_q.delete();
        cmd_op = op;
        cmd_addr = ad;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 9000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 9000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 9000) begin
            error_cnt++;
            results();
        end
        case (op)
            nvsd_pkg::OP_READ: begin
                want_q.push_back({2'b01, ad});
                check(rsp_rdata, exp_mem[ad]);
            end
            nvsd_pkg::OP_WRITE: begin
                want_q.push_back({2'b10, ad});
                exp_mem[ad] = wd;
            end
            nvsd_pkg::OP_RESTORE: begin
                add_seq(15'h0c63);
                exp_mem = exp_nv;
            end
            nvsd_pkg::OP_PSAVE_OFF, nvsd_pkg::OP_PSAVE_ON: begin
                exp_psave = (op == nvsd_pkg::OP_PSAVE_ON);
                add_seq(exp_psave ? 15'h0b46 : 15'h0b45);
                check(u_nvsd_mem_model.power_fail_save, exp_psave);
            end
            default: ;
        endcase
        if (op >= nvsd_pkg::OP_SAVE && op != nvsd_pkg::OP_RESTORE) begin
            add_seq(15'h0fc0);
            exp_nv = exp_mem;
            check(busy_lows - b, 1);
        end
        check(pin_log.size(), want_q.size());
        foreach (want_q[k]) check(pin_log[k], want_q[k]);
    endtask

    initial begin
        seed = 32'h112e08f5;
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = nvsd_pkg::OP_READ;
        cmd_addr = 15'h0000;
        cmd_wdata = 8'h00;
        error_cnt = 0;
        n_checks = 0;
        busy_lows = 0;
        exp_psave = 1'b1;
        exp_mem = '{default: 8'h00};
        exp_nv = '{default: 8'h00};
        repeat (12) @(posedge mclk);
        #1;
        nrst = 1'b1;
        run(nvsd_pkg::OP_READ, 15'h7fff, 8'h00);
        for (i = 0; i < 8; i++) begin
            run(nvsd_pkg::OP_WRITE, 15'($random(seed)), 8'($random(seed)));
            run(nvsd_pkg::OP_READ, cmd_addr, 8'h00);
        end
        run(nvsd_pkg::OP_WRITE, 15'h0e38, 8'h5a);
        run(nvsd_pkg::OP_SAVE, 15'h0000, 8'h00);
        run(nvsd_pkg::OP_SAVE, 15'h0000, 8'h00);
        run(nvsd_pkg::OP_WRITE, 15'h0e38, 8'ha5);
        run(nvsd_pkg::OP_READ, 15'h0e38, 8'h00);
        run(nvsd_pkg::OP_RESTORE, 15'h0000, 8'h00);
        run(nvsd_pkg::OP_READ, 15'h0e38, 8'h00);
        run(nvsd_pkg::OP_PSAVE_OFF, 15'h0000, 8'h00);
        run(nvsd_pkg::OP_PSAVE_ON, 15'h0000, 8'h00);
        // save started by the device itself: host must hold off while busy is low
        i = busy_lows;
        -> u_nvsd_mem_model.go_save;
        repeat (8) @(posedge mclk);
        #1;
        exp_nv = exp_mem;
        run(nvsd_pkg::OP_READ, 15'h0e38, 8'h00);
        check(busy_lows, i + 1);
        // core supply low: the device drops the write
        u_nvsd_mem_model.core_ok = 1'b0;
        run(nvsd_pkg::OP_WRITE, 15'h0e38, 8'hc3);
        u_nvsd_mem_model.core_ok = 1'b1;
        exp_mem[15'h0e38] = 8'h5a;
        run(nvsd_pkg::OP_READ, 15'h0e38, 8'h00);
        run(nvsd_pkg::OP_READ, 15'h0e3b, 8'h00);
        check(u_nvsd_mem_model.bad_cnt, 0);
        results();
    end
endmodule // testbench
